// file: xocr_pkg.sv
// package for the crystal oscillator configuration register bank
// assumes a byte-wide register access port driven by the serial host decoder
package xocr_pkg;

  // ********************************************************************
  // register offsets
  // ********************************************************************
  localparam logic [6:0] OFS_GAIN  = 7'h00;
  localparam logic [6:0] OFS_DRIVE = 7'h01;
  localparam logic [6:0] OFS_LOAD  = 7'h02;
  localparam logic [6:0] OFS_RUN   = 7'h03;

  // ********************************************************************
  // reset values
  // ********************************************************************
  localparam logic [7:0] RST_GAIN  = 8'hff;
  localparam logic [7:0] RST_DRIVE = 8'h04;
  localparam logic [7:0] RST_LOAD  = 8'h40;
  localparam logic       RST_RUN   = 1'b1;

  // ********************************************************************
  // field positions and codes
  // ********************************************************************
  localparam int         GAIN_BLOCKS   = 4;
  localparam int         DRIVE_BITS    = 7;
  localparam int         LOAD_BITS     = 7;
  localparam int         RUN_BIT       = 0;
  localparam logic [1:0] SEL_DIFF0     = 2'h0;
  localparam logic [1:0] SEL_DIFF1     = 2'h1;
  localparam logic [1:0] SEL_CRYSTAL   = 2'h2;
  localparam logic [1:0] SEL_BYPASS    = 2'h3;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  // register access port
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } xocr_req_t;

  // static controls into the analog crystal circuit
  typedef struct packed {
    logic [GAIN_BLOCKS-1:0] gain_blk_en;
    logic [DRIVE_BITS-1:0]  damp_res_en;
    logic [LOAD_BITS-1:0]   load_cap_en;
    logic                   buf_enable;
  } xocr_analog_t;

endpackage : xocr_pkg

// file: xocr_gain_map.sv
// maps the gain register onto the four equal gain blocks
// assumes a static register value on the same clock
module xocr_gain_map (
  input  wire logic [7:0]                     gain_code,
  output logic      [xocr_pkg::GAIN_BLOCKS-1:0] blk_en
);

  // ********************************************************************
  // one block per bit pair
  // ********************************************************************
  genvar i;
  generate
    for (i = 0; i < xocr_pkg::GAIN_BLOCKS; i++)
    begin : g_blk
      // a pair adds its block only when both bits are set
      assign blk_en[i] = gain_code[2*i] & gain_code[2*i+1];
    end
  endgenerate

endmodule : xocr_gain_map

// file: xocr_run_ctl.sv
// decides whether the crystal buffer runs from policy and input select
// assumes input_select comes from logic on the same clock
module xocr_run_ctl (
  input  wire logic       run_policy,
  input  wire logic [1:0] input_select,
  output logic            buf_run
);

  // ********************************************************************
  // run decision
  // ********************************************************************
  always_comb
  begin
    if (!run_policy)
      buf_run = 1'b1;
    else
      buf_run = (input_select == xocr_pkg::SEL_CRYSTAL);
  end

endmodule : xocr_run_ctl

// file: xocr_regs.sv
// crystal oscillator configuration register bank with analog control outputs
// assumes a decoded byte access port on clk_sys and input_select from the same clock

// Function
// - each gain bit pair enables one block
// - gain register 8 bits, resets to ff
// - policy high, bypass or differential disables buffer
// - policy low keeps buffer forced running
// - drive bits 6..0 enable damping resistors
// - all bits smallest, bit0 only highest
// - zero disables resistors, bit 7 unused
// - drive level register resets to 04
// - load capacitance 0 to 21.75 pF
// - load bits add weighted capacitors, combinable
// - load capacitance register resets to 40
// - policy high runs only in crystal mode
// - policy low keeps oscillator running always
// - policy bit 0 resets 1, upper zero
// - select codes crystal 10, bypass 11
module xocr_regs (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire xocr_pkg::xocr_req_t    req,
  input  wire logic [1:0]             input_select,
  output xocr_pkg::xocr_analog_t      analog_r,
  output logic [7:0]                  rdata_r,
  output logic                        rvalid_r
);

  // ********************************************************************
  // register storage
  // ********************************************************************
  logic [7:0]                       gain_r;
  logic [7:0]                       drive_r;
  logic [7:0]                       load_r;
  logic                             run_r;
  logic [xocr_pkg::GAIN_BLOCKS-1:0] blk_en;
  logic                             buf_run;
  logic [7:0]                       rd_nxt;

  // writes land in one cycle; the analog sees new codes one cycle after that
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      gain_r  <= xocr_pkg::RST_GAIN;
      drive_r <= xocr_pkg::RST_DRIVE;
      load_r  <= xocr_pkg::RST_LOAD;
      run_r   <= xocr_pkg::RST_RUN;
    end
    else if (req.wr)
    begin
      unique case (req.addr)
        xocr_pkg::OFS_GAIN:  gain_r  <= req.wdata;
        xocr_pkg::OFS_DRIVE: drive_r <= req.wdata;
        xocr_pkg::OFS_LOAD:  load_r  <= req.wdata;
        xocr_pkg::OFS_RUN:   run_r   <= req.wdata[xocr_pkg::RUN_BIT];
        default: ;
      endcase
    end
  end

  // ********************************************************************
  // read mux
  // ********************************************************************
  always_comb
  begin
    unique case (req.addr)
      xocr_pkg::OFS_GAIN:  rd_nxt = gain_r;
      xocr_pkg::OFS_DRIVE: rd_nxt = drive_r;
      xocr_pkg::OFS_LOAD:  rd_nxt = load_r;
      xocr_pkg::OFS_RUN:   rd_nxt = {7'h00, run_r};
      default:             rd_nxt = xocr_pkg::READ_UNMAPPED;
    endcase
  end

  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      rdata_r  <= 8'h00;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rvalid_r <= req.rd;
      if (req.rd)
        rdata_r <= rd_nxt;
    end
  end

  // ********************************************************************
  // analog control codes
  // ********************************************************************
  xocr_gain_map u_gain (
    .gain_code (gain_r),
    .blk_en    (blk_en)
  );

  xocr_run_ctl u_run (
    .run_policy   (run_r),
    .input_select (input_select),
    .buf_run      (buf_run)
  );

  // parallel resistors: each set bit lowers resistance, bit 7 ignored
  // registered outputs add one cycle after the write; harmless for static codes
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      analog_r <= '0;
    else
    begin
      analog_r.gain_blk_en <= blk_en;
      analog_r.damp_res_en <= drive_r[xocr_pkg::DRIVE_BITS-1:0];
      analog_r.load_cap_en <= load_r[xocr_pkg::LOAD_BITS-1:0];
      analog_r.buf_enable  <= buf_run;
    end
  end

  // ********************************************************************
  // checks
  // ********************************************************************
  AST_GAIN_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
    req.wr && req.addr == xocr_pkg::OFS_GAIN |=> gain_r == $past(req.wdata))
    else $error("gain write lost");

  AST_GAIN_MAP: assert property (@(posedge clk_sys) disable iff (rst)
    gain_r == 8'hff [*2] |-> analog_r.gain_blk_en == 4'hf)
    else $error("full gain not all blocks");

  AST_RUN_LOW: assert property (@(posedge clk_sys) disable iff (rst)
    !run_r [*2] |-> analog_r.buf_enable)
    else $error("forced run not running");

  AST_RUN_BYPASS: assert property (@(posedge clk_sys) disable iff (rst)
    run_r && input_select != xocr_pkg::SEL_CRYSTAL |=> !analog_r.buf_enable)
    else $error("buffer on while not selected");

  AST_RUN_XTAL: assert property (@(posedge clk_sys) disable iff (rst)
    run_r && input_select == xocr_pkg::SEL_CRYSTAL |=> analog_r.buf_enable)
    else $error("buffer off in crystal mode");

  AST_DRIVE_BIT7: assert property (@(posedge clk_sys) disable iff (rst)
    req.wr && req.addr == xocr_pkg::OFS_DRIVE ##2 1 |-> analog_r.damp_res_en == $past(req.wdata[6:0], 2))
    else $error("drive code not applied");

  AST_LOAD_APPLY: assert property (@(posedge clk_sys) disable iff (rst)
    req.wr && req.addr == xocr_pkg::OFS_LOAD ##2 1 |-> analog_r.load_cap_en == $past(req.wdata[6:0], 2))
    else $error("load code not applied");

  AST_RUN_READ: assert property (@(posedge clk_sys) disable iff (rst)
    req.rd && req.addr == xocr_pkg::OFS_RUN |=> rvalid_r && rdata_r[7:1] == 7'h00)
    else $error("policy upper bits not zero");

  AST_DRIVE_READ: assert property (@(posedge clk_sys) disable iff (rst)
    req.rd && req.addr == xocr_pkg::OFS_DRIVE |=> rdata_r == $past(drive_r))
    else $error("drive readback wrong");

  // ********************************************************************
  // write landing per register
  // ********************************************************************
  AST_DRIVE_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
    req.wr && req.addr == xocr_pkg::OFS_DRIVE |=> drive_r == $past(req.wdata))
    else $error("drive write lost");

  AST_LOAD_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
    req.wr && req.addr == xocr_pkg::OFS_LOAD |=> load_r == $past(req.wdata))
    else $error("load write lost");

  AST_RUN_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
    req.wr && req.addr == xocr_pkg::OFS_RUN |=> run_r == $past(req.wdata[xocr_pkg::RUN_BIT]))
    else $error("policy write lost");

  // unmapped writes must leave every field untouched
  AST_UNMAPPED_WRITE: assert property (@(posedge clk_sys) disable iff (rst)
    req.wr && req.addr > xocr_pkg::OFS_RUN |=>
      $stable(gain_r) && $stable(drive_r) && $stable(load_r) && $stable(run_r))
    else $error("unmapped write changed a field");

  // ********************************************************************
  // read side
  // ********************************************************************
  AST_RVALID_PULSE: assert property (@(posedge clk_sys) disable iff (rst)
    !req.rd |=> !rvalid_r)
    else $error("read valid without a read");

  AST_UNMAPPED_READ: assert property (@(posedge clk_sys) disable iff (rst)
    req.rd && req.addr > xocr_pkg::OFS_RUN |=> rdata_r == xocr_pkg::READ_UNMAPPED)
    else $error("unmapped read not zero");

  AST_GAIN_READ: assert property (@(posedge clk_sys) disable iff (rst)
    req.rd && req.addr == xocr_pkg::OFS_GAIN |=> rdata_r == $past(gain_r))
    else $error("gain readback wrong");

  AST_LOAD_READ: assert property (@(posedge clk_sys) disable iff (rst)
    req.rd && req.addr == xocr_pkg::OFS_LOAD |=> rdata_r == $past(load_r))
    else $error("load readback wrong");

  // read data must not drift between reads
  AST_RDATA_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    !req.rd |=> $stable(rdata_r))
    else $error("read data moved without a read");

  // ********************************************************************
  // analog code mapping
  // ********************************************************************
  AST_GAIN_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
    gain_r == 8'h00 [*2] |-> analog_r.gain_blk_en == 4'h0)
    else $error("minimum gain left blocks on");

  AST_DRIVE_ZERO: assert property (@(posedge clk_sys) disable iff (rst)
    drive_r[6:0] == 7'h00 [*2] |-> analog_r.damp_res_en == 7'h00)
    else $error("resistor on with zero drive code");

  AST_RUN_FORCED: assert property (@(posedge clk_sys) disable iff (rst)
    !run_r |=> analog_r.buf_enable)
    else $error("oscillator stopped under forced run");

endmodule : xocr_regs

// file: xocr_xtal_model.sv
// partner model: analog crystal circuit and input multiplexer
// assumes the register bank runs on the same clk_sys
module xocr_xtal_model (
  input  wire logic                   clk_sys,
  input  wire logic                   rst,
  input  wire logic [1:0]             sel_cmd,
  input  wire xocr_pkg::xocr_analog_t analog,
  output logic [1:0]                  input_select,
  output logic                        osc_run
);
  // ****************************************************************
  // mux select and oscillator state
  // ****************************************************************
  // select is registered, as the select register it stands for would be
  always_ff @(posedge clk_sys or posedge rst)
    if (rst)
      input_select <= xocr_pkg::SEL_DIFF0;
    else
      input_select <= sel_cmd;
  assign osc_run = analog.buf_enable;
endmodule : xocr_xtal_model

// file: testbench.sv
// self-checking bench for the crystal oscillator register bank
// assumes decoded byte access and a select driven by the partner model
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // signals and instances
  // ****************************************************************
  logic                   clk_sys, rst, rvalid_r, osc_run;
  xocr_pkg::xocr_req_t    req;
  xocr_pkg::xocr_analog_t analog_r;
  logic [1:0]             sel_cmd, input_select;
  logic [7:0]             rdata_r, d;
  int                     error_cnt, checks;
  xocr_regs dut (.clk_sys(clk_sys), .rst(rst), .req(req), .input_select(input_select),
                 .analog_r(analog_r), .rdata_r(rdata_r), .rvalid_r(rvalid_r));
  xocr_xtal_model xtal (.clk_sys(clk_sys), .rst(rst), .sel_cmd(sel_cmd), .analog(analog_r),
                        .input_select(input_select), .osc_run(osc_run));
  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // ****************************************************************
  // tasks
  // ****************************************************************
  task report_and_stop;
    $display("checks=%0d errors=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // analog outputs settle one edge after the taking edge
  task wr(input logic [6:0] a, input logic [7:0] v);
    @(posedge clk_sys) #1;
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = v;
    @(posedge clk_sys) #1;
    req.wr = 1'b0;
    @(posedge clk_sys) #1;
  endtask : wr
  task rd(input logic [6:0] a, output logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk_sys) #1;
    req.rd = 1'b1;
    req.addr = a;
    @(posedge clk_sys) #1;
    req.rd = 1'b0;
    while (rvalid_r !== 1'b1 && n < 4)
    begin
      @(posedge clk_sys) #1;
      n++;
    end
    if (n == 4)
    begin
      error_cnt++;
      report_and_stop();
    end
    v = rdata_r;
  endtask : rd
  task t_reset;
    rd(xocr_pkg::OFS_GAIN, d);  chk(d, 8'hff);
    rd(xocr_pkg::OFS_DRIVE, d); chk(d, 8'h04);
    rd(xocr_pkg::OFS_LOAD, d);  chk(d, 8'h40);
    rd(xocr_pkg::OFS_RUN, d);   chk(d, 8'h01);
    rd(7'h04, d);               chk(d, 8'h00);
    chk({4'h0, analog_r.gain_blk_en}, 8'h0f);
    chk({1'b0, analog_r.damp_res_en}, 8'h04);
    chk({1'b0, analog_r.load_cap_en}, 8'h40);
    $display("reset test done");
  endtask : t_reset
  task t_fields;
    wr(xocr_pkg::OFS_DRIVE, 8'hff); chk({1'b0, analog_r.damp_res_en}, 8'h7f);
    rd(xocr_pkg::OFS_DRIVE, d);     chk(d, 8'hff);
    wr(xocr_pkg::OFS_DRIVE, 8'h80); chk({1'b0, analog_r.damp_res_en}, 8'h00);
    wr(xocr_pkg::OFS_LOAD, 8'h7f);  chk({1'b0, analog_r.load_cap_en}, 8'h7f);
    wr(xocr_pkg::OFS_GAIN, 8'h3c);  chk({4'h0, analog_r.gain_blk_en}, 8'h06);
    wr(xocr_pkg::OFS_GAIN, 8'h00);  chk({4'h0, analog_r.gain_blk_en}, 8'h00);
    wr(7'h05, 8'h55);
    rd(xocr_pkg::OFS_LOAD, d);      chk(d, 8'h7f);
    wr(xocr_pkg::OFS_RUN, 8'hfe);
    rd(xocr_pkg::OFS_RUN, d);       chk(d, 8'h00);
    $display("field test done");
  endtask : t_fields
  // every select code under both policies; select and buffer each lag one edge
  task t_run;
    for (int p = 0; p < 2; p++)
      for (int s = 0; s < 4; s++)
      begin
        wr(xocr_pkg::OFS_RUN, 8'(p));
        sel_cmd = 2'(s);
        repeat (3) @(posedge clk_sys);
        #1;
        chk({7'h0, osc_run}, (p == 0 || s == 2) ? 8'h01 : 8'h00);
      end
    $display("run policy test done");
  endtask : t_run
  // a read and a write on one edge: the read returns the old byte, data then holds
  task t_rw_same;
    wr(xocr_pkg::OFS_GAIN, 8'h0f);
    @(posedge clk_sys) #1;
    req.wr = 1'b1;
    req.rd = 1'b1;
    req.addr = xocr_pkg::OFS_GAIN;
    req.wdata = 8'hf0;
    @(posedge clk_sys) #1;
    req.wr = 1'b0;
    req.rd = 1'b0;
    chk(rdata_r, 8'h0f);
    chk({7'h0, rvalid_r}, 8'h01);
    @(posedge clk_sys) #1;
    chk({7'h0, rvalid_r}, 8'h00);
    chk(rdata_r, 8'h0f);
    chk({4'h0, analog_r.gain_blk_en}, 8'h0c);
    $display("read write same edge test done");
  endtask : t_rw_same
  // reset in mid-run clears analog codes, then the first edge after release loads the register reset values
  task t_midreset;
    wr(xocr_pkg::OFS_LOAD, 8'h01);
    wr(xocr_pkg::OFS_DRIVE, 8'h02);
    rst = 1'b1;
    #1;
    chk({1'b0, analog_r.load_cap_en}, 8'h00);
    repeat (2) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    @(posedge clk_sys) #1;
    chk({1'b0, analog_r.load_cap_en}, 8'h40);
    chk({1'b0, analog_r.damp_res_en}, 8'h04);
    rd(xocr_pkg::OFS_GAIN, d); chk(d, 8'hff);
    rd(xocr_pkg::OFS_RUN, d);  chk(d, 8'h01);
    $display("mid-run reset test done");
  endtask : t_midreset
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    error_cnt = 0;
    checks = 0;
    rst = 1'b1;
    req = '0;
    sel_cmd = xocr_pkg::SEL_CRYSTAL;
    repeat (16) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_reset();
    t_fields();
    t_run();
    t_rw_same();
    t_midreset();
    report_and_stop();
  end
endmodule : testbench
